/* hdl/ipv4_tx_device.sv */
// How it works
// R1 - Frame type 0x20 at offset three, dispatched
// R2 - Nonzero frame ID requests status; zero suppresses
// R3 - Destination address offsets 5-8, all-ones UDP broadcast
// R4 - Destination port at offsets 9-10, big-endian
// R5 - UDP source port equals listening port setting
// R6 - New TCP connection uses source port zero
// R7 - Protocol byte offset 13: 0 UDP, 1 TCP
// R8 - Options bit 1 closes TCP socket after send
// R9 - Close option ignored for UDP
// R10 - Host drives reserved option bits to zero
// R11 - Payload from offset 15, at most 1400 bytes
// R12 - Reported maximum payload is eight bytes less
// R13 - Delimiter 0x7E then big-endian length
// R14 - Checksum is 0xFF minus byte sum, bad dropped; the device only flags frame_bad_o, its payload already passed on
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "ipv4_framer_regs.svh"

// ********************************************************************
// Two-entry buffer
// ********************************************************************
module ipv4_pair_buffer #(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] in_data_i,
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	output logic      [W-1:0] out_data_o,
	output logic              out_valid_o,
	input  wire logic         out_ready_i
);
	logic [W-1:0] d0_q;
	logic [W-1:0] d1_q;
	logic         v0_q;
	logic         v1_q;
	logic         room_q;

	wire push = in_valid_i && !v1_q;
	wire pop  = v0_q && out_ready_i;

	assign in_ready_o  = room_q;
	assign out_data_o  = d0_q;
	assign out_valid_o = v0_q;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			d0_q <= '0;
			d1_q <= '0;
			v0_q <= 1'b0;
			v1_q <= 1'b0;
			room_q <= 1'b1;
		end else if (pop) begin
			d0_q <= v1_q ? d1_q : in_data_i;
			v0_q <= v1_q || push;
			d1_q <= in_data_i;
			v1_q <= v1_q && push;
			room_q <= !(v1_q && push);
		end else if (push && !v0_q) begin
			d0_q <= in_data_i;
			v0_q <= 1'b1;
		end else if (push) begin
			d1_q <= in_data_i;
			v1_q <= 1'b1;
			room_q <= 1'b0;
		end
	end
endmodule : ipv4_pair_buffer

// ********************************************************************
// Device end: frame checker and field splitter
// ********************************************************************
module ipv4_tx_device
	import ipv4_framer_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	ipv4_link_if.dev_end     link,
	output logic      [7:0]  frame_id_o,
	output logic      [31:0] dest_addr_o,
	output logic      [15:0] dest_port_o,
	output logic      [15:0] src_port_o,
	output logic             proto_tcp_o,
	output logic             close_socket_o,
	output logic             broadcast_o,
	output logic             status_wanted_o,
	output logic             hdr_valid_o,
	output logic      [7:0]  pay_data_o,
	output logic             pay_valid_o,
	input  wire logic        pay_ready_i,
	output logic             frame_good_o,
	output logic             frame_bad_o,
	output logic             frame_other_o,
	output logic      [10:0] max_payload_query_o
);
	// ****************************************************************
	// State
	// ****************************************************************
	dev_state_e  state_q;
	logic [15:0] len_q;
	logic [10:0] off_q;
	logic [7:0]  sum_q;
	logic        type_ok_q;
	logic [7:0]  id_q;
	logic [31:0] addr_q;
	logic [15:0] dport_q;
	logic [15:0] sport_q;
	logic [7:0]  proto_q;
	logic        close_q;
	logic        bcast_q;
	logic        stat_q;
	logic        hdr_q;
	logic        good_q;
	logic        bad_q;
	logic        other_q;
	logic [10:0] pay_query_q;
	logic        buf_ready;

	// ****************************************************************
	// Decode
	// ****************************************************************
	// Link is only taken while the buffer has room, so no word is lost
	wire        acc       = link.valid && buf_ready;
	wire [7:0]  b         = link.data;
	wire [15:0] len_w     = {len_q[15:8], b};
	wire        len_bad   = (len_w == 16'h0000) || (len_w > `LEN_MAX);   // [R11]
	wire [10:0] end_off   = 11'(len_q[10:0] + 11'h002);
	wire        is_tx4    = (b == `FRM_TYPE_TX4);                        // [R1]
	wire        in_body   = acc && (state_q == D_BODY);
	wire        take      = in_body && type_ok_q;
	wire        is_tcp    = (proto_q == `PROTO_TCP);                     // [R7]
	wire        is_udp    = (proto_q == `PROTO_UDP);
	wire        sum_ok    = (8'(sum_q + b) == `CSUM_BASE);               // [R14]
	wire        short     = len_q < 16'(`HDR_LEN);
	wire        proto_bad = !is_tcp && !is_udp;
	wire        pay_push  = take && (off_q >= `OFS_PAY);                 // [R11]
	wire        csum_in   = acc && (state_q == D_CSUM);

	assign link.ready          = buf_ready;
	assign frame_id_o          = id_q;
	assign dest_addr_o         = addr_q;
	assign dest_port_o         = dport_q;
	assign src_port_o          = sport_q;
	assign proto_tcp_o         = proto_q[0];
	assign close_socket_o      = close_q;
	assign broadcast_o         = bcast_q;
	assign status_wanted_o     = stat_q;
	assign hdr_valid_o         = hdr_q;
	assign frame_good_o        = good_q;
	assign frame_bad_o         = bad_q;
	assign frame_other_o       = other_q;
	assign max_payload_query_o = pay_query_q;

	ipv4_pair_buffer #(
		.W(8)
	) u_pay_buf (
		.sys_clk_i  (sys_clk_i),
		.reset_i    (reset_i),
		.in_data_i  (b),
		.in_valid_i (pay_push),
		.in_ready_o (buf_ready),
		.out_data_o (pay_data_o),
		.out_valid_o(pay_valid_o),
		.out_ready_i(pay_ready_i)
	);

	// ****************************************************************
	// Frame walker
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q   <= D_HUNT;
			len_q     <= 16'h0000;
			off_q     <= 11'h000;
			sum_q     <= 8'h00;
			type_ok_q <= 1'b0;
		end else if (acc) begin
			off_q <= off_q + 11'h001;
			case (state_q)
				D_HUNT: begin
					if (b == `FRM_DELIM) begin                       // [R13]
						state_q <= D_LEN_HI;
						off_q   <= 11'h001;
					end
				end
				D_LEN_HI: begin
					len_q   <= {b, 8'h00};                           // [R13]
					state_q <= D_LEN_LO;
				end
				D_LEN_LO: begin
					len_q   <= len_w;
					sum_q   <= 8'h00;
					state_q <= len_bad ? D_HUNT : D_BODY;            // [R11]
				end
				D_BODY: begin
					sum_q <= sum_q + b;                              // [R14]
					if (off_q == `OFS_TYPE) begin
						type_ok_q <= is_tx4;                         // [R1]
					end
					if (off_q == end_off) begin
						state_q <= D_CSUM;
					end
				end
				D_CSUM: state_q <= D_HUNT;
				default: state_q <= D_HUNT;
			endcase
		end
	end

	// ****************************************************************
	// Header fields
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			id_q    <= 8'h00;
			addr_q  <= 32'h0000_0000;
			dport_q <= 16'h0000;
			sport_q <= 16'h0000;
			proto_q <= 8'h00;
		end else if (take) begin
			if (off_q == `OFS_ID) begin
				id_q <= b;                                           // [R2]
			end
			if (off_q >= `OFS_ADDR_MSB && off_q <= `OFS_ADDR_LSB) begin
				addr_q <= {addr_q[23:0], b};                         // [R3]
			end
			if (off_q == `OFS_DPORT_MSB || off_q == `OFS_DPORT_LSB) begin
				dport_q <= {dport_q[7:0], b};                        // [R4]
			end
			// Source port is passed on as sent; its value is the host's duty
			if (off_q == `OFS_SPORT_MSB || off_q == `OFS_SPORT_LSB) begin
				sport_q <= {sport_q[7:0], b};                        // [R5] [R6]
			end
			if (off_q == `OFS_PROTO) begin
				proto_q <= b;                                        // [R7]
			end
		end
	end

	// ****************************************************************
	// Decisions and reports
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			close_q <= 1'b0;
			bcast_q <= 1'b0;
			stat_q  <= 1'b0;
			hdr_q   <= 1'b0;
			good_q  <= 1'b0;
			bad_q   <= 1'b0;
			other_q <= 1'b0;
			pay_query_q <= 11'h000;
		end else begin
			pay_query_q <= `MAX_PAY - `QUERY_REDUCE;                 // [R12]
			hdr_q <= take && (off_q == `OFS_OPTS);
			if (take && off_q == `OFS_OPTS) begin
				// Reserved option bits are not checked, only ignored
				close_q <= b[`OPT_CLOSE_BIT] && is_tcp;              // [R8] [R9] [R10]
				bcast_q <= (addr_q == `ADDR_BCAST) && is_udp;        // [R3]
				stat_q  <= (id_q != 8'h00);                          // [R2]
			end
			good_q  <= csum_in && type_ok_q && sum_ok && !short && !proto_bad;
			bad_q   <= (csum_in && type_ok_q && !(sum_ok && !short && !proto_bad))
			           || (acc && state_q == D_LEN_LO && len_bad);   // [R14] [R11]
			other_q <= csum_in && !type_ok_q;                        // [R1]
		end
	end
endmodule : ipv4_tx_device
`default_nettype wire

/* hdl/ipv4_framer_regs.svh */
`ifndef IPV4_FRAMER_REGS_SVH
`define IPV4_FRAMER_REGS_SVH

// ********************************************************************
// Frame bytes and offsets
// ********************************************************************
`define FRM_DELIM       8'h7E
`define FRM_TYPE_TX4    8'h20
`define OFS_TYPE        11'h003
`define OFS_ID          11'h004
`define OFS_ADDR_MSB    11'h005
`define OFS_ADDR_LSB    11'h008
`define OFS_DPORT_MSB   11'h009
`define OFS_DPORT_LSB   11'h00A
`define OFS_SPORT_MSB   11'h00B
`define OFS_SPORT_LSB   11'h00C
`define OFS_PROTO       11'h00D
`define OFS_OPTS        11'h00E
`define OFS_PAY         11'h00F
`define HDR_LEN         11'h00C
`define MAX_PAY         11'h0578
`define QUERY_REDUCE    11'h008
`define LEN_MAX         16'h0584
`define CSUM_BASE       8'hFF
`define PROTO_UDP       8'h00
`define PROTO_TCP       8'h01
`define OPT_CLOSE_BIT   1
`define OPT_VALID_MASK  8'h02
`define ADDR_BCAST      32'hFFFF_FFFF

// ********************************************************************
// Host controller registers
// ********************************************************************
`define REG_DEST        8'h00
`define REG_PORTS       8'h04
`define REG_CTRL        8'h08
`define REG_STATUS      8'h0C
`define CTRL_ID_LSB     0
`define CTRL_OPT_LSB    8
`define CTRL_PROTO_BIT  16
`define CTRL_NEWC_BIT   17
`define CTRL_LEN_LSB    18
`define CTRL_GO_BIT     31
`define STAT_BUSY_BIT   0
`define STAT_ERR_BIT    1
`define STAT_DONE_BIT   2

`endif

/* hdl/ipv4_framer_pkg.sv */
package ipv4_framer_pkg;
	typedef logic [7:0] byte_t;
	typedef enum {D_HUNT, D_LEN_HI, D_LEN_LO, D_BODY, D_CSUM} dev_state_e;
	typedef enum {H_IDLE, H_SEND, H_SUM} host_state_e;
endpackage : ipv4_framer_pkg

/* hdl/ipv4_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ipv4_link_if (
	input wire logic sys_clk_i,
	input wire logic reset_i
);
	logic [7:0] data;
	logic       valid;
	logic       ready;

	modport host_end (output data, output valid, input ready);
	modport dev_end  (input data, input valid, output ready);
endinterface : ipv4_link_if
`default_nettype wire

/* hdl/ipv4_tx_host.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ipv4_framer_regs.svh"
module ipv4_tx_host
	import ipv4_framer_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        we_i,
	input  wire logic        re_i,
	output logic      [31:0] rdata_o,
	input  wire logic [7:0]  pay_data_i,
	input  wire logic        pay_valid_i,
	output logic             pay_ready_o,
	ipv4_link_if.host_end    link
);
	// ****************************************************************
	// Registers
	// ****************************************************************
	host_state_e state_q;
	logic [31:0] dest_q;
	logic [15:0] dport_q;
	logic [15:0] listen_q;
	logic [7:0]  id_q;
	logic [7:0]  opts_q;
	logic        proto_q;
	logic        newc_q;
	logic [10:0] plen_q;
	logic        err_q;
	logic        done_q;
	logic [31:0] rdata_q;
	logic [10:0] off_q;
	logic [7:0]  sum_q;
	logic [7:0]  tx_data_q;
	logic        tx_valid_q;
	logic [7:0]  hold_q;
	logic        hold_empty_q;

	// ****************************************************************
	// Decode and byte selection
	// ****************************************************************
	wire        wr_ctrl   = we_i && (addr_i == `REG_CTRL);
	wire        wr_stat   = we_i && (addr_i == `REG_STATUS);
	wire        idle      = (state_q == H_IDLE);
	wire [10:0] req_len   = wdata_i[`CTRL_LEN_LSB +: 11];
	wire        go        = wr_ctrl && wdata_i[`CTRL_GO_BIT] && idle;
	wire        too_long  = req_len > `MAX_PAY;                          // [R11]
	wire [15:0] len_field = 16'(plen_q) + 16'(`HDR_LEN);                 // [R13]
	wire [10:0] last_off  = 11'(len_field[10:0] + 11'h002);
	wire        is_pay    = off_q >= `OFS_PAY;
	wire        avail     = !is_pay || !hold_empty_q;
	wire        load      = !tx_valid_q || link.ready;
	wire        issue     = (state_q == H_SEND) && load && avail;
	wire        sum_out   = (state_q == H_SUM) && load;
	// UDP must use the listening port; a new TCP connection uses zero
	wire [15:0] sport     = (proto_q && newc_q) ? 16'h0000 : listen_q;  // [R5] [R6]
	wire [7:0]  hdr_w [15];

	assign hdr_w[0]  = `FRM_DELIM;                                       // [R13]
	assign hdr_w[1]  = len_field[15:8];
	assign hdr_w[2]  = len_field[7:0];
	assign hdr_w[3]  = `FRM_TYPE_TX4;                                    // [R1]
	assign hdr_w[4]  = id_q;                                             // [R2]
	assign hdr_w[5]  = dest_q[31:24];                                    // [R3]
	assign hdr_w[6]  = dest_q[23:16];
	assign hdr_w[7]  = dest_q[15:8];
	assign hdr_w[8]  = dest_q[7:0];
	assign hdr_w[9]  = dport_q[15:8];                                    // [R4]
	assign hdr_w[10] = dport_q[7:0];
	assign hdr_w[11] = sport[15:8];
	assign hdr_w[12] = sport[7:0];
	assign hdr_w[13] = proto_q ? `PROTO_TCP : `PROTO_UDP;                // [R7]
	assign hdr_w[14] = opts_q & `OPT_VALID_MASK;                         // [R10]

	wire [7:0]  byte_w  = is_pay ? hold_q : hdr_w[off_q[3:0]];
	wire [7:0]  rd_stat = {5'h00, done_q, err_q, !idle};
	wire [31:0] rd_mux  = (addr_i == `REG_DEST)   ? dest_q :
	                      (addr_i == `REG_PORTS)  ? {dport_q, listen_q} :
	                      (addr_i == `REG_STATUS) ? {24'h00_0000, rd_stat} : 32'h0000_0000;

	assign rdata_o     = rdata_q;
	assign pay_ready_o = hold_empty_q;
	assign link.data   = tx_data_q;
	assign link.valid  = tx_valid_q;

	// ****************************************************************
	// Register file
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			dest_q   <= 32'h0000_0000;
			dport_q  <= 16'h0000;
			listen_q <= 16'h0000;
			rdata_q  <= 32'h0000_0000;
		end else begin
			rdata_q <= re_i ? rd_mux : 32'h0000_0000;
			if (we_i && idle && addr_i == `REG_DEST) begin
				dest_q <= wdata_i;
			end
			if (we_i && idle && addr_i == `REG_PORTS) begin
				dport_q  <= wdata_i[31:16];
				listen_q <= wdata_i[15:0];
			end
		end
	end

	// Sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			err_q  <= 1'b0;
			done_q <= 1'b0;
		end else begin
			err_q  <= (go && too_long) || (err_q && !(wr_stat && wdata_i[`STAT_ERR_BIT]));
			done_q <= sum_out || (done_q && !(wr_stat && wdata_i[`STAT_DONE_BIT]));
		end
	end

	// ****************************************************************
	// Payload holding byte
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			hold_q       <= 8'h00;
			hold_empty_q <= 1'b1;
		end else if (pay_valid_i && hold_empty_q) begin
			hold_q       <= pay_data_i;
			hold_empty_q <= 1'b0;
		end else if (issue && is_pay) begin
			hold_empty_q <= 1'b1;
		end
	end

	// ****************************************************************
	// Frame sender
	// ****************************************************************
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_q    <= H_IDLE;
			id_q       <= 8'h00;
			opts_q     <= 8'h00;
			proto_q    <= 1'b0;
			newc_q     <= 1'b0;
			plen_q     <= 11'h000;
			off_q      <= 11'h000;
			sum_q      <= 8'h00;
			tx_data_q  <= 8'h00;
			tx_valid_q <= 1'b0;
		end else begin
			if (load) begin
				tx_valid_q <= issue || sum_out;
			end
			case (state_q)
				H_IDLE: begin
					if (go && !too_long) begin                       // [R11]
						id_q    <= wdata_i[`CTRL_ID_LSB +: 8];
						opts_q  <= wdata_i[`CTRL_OPT_LSB +: 8];
						proto_q <= wdata_i[`CTRL_PROTO_BIT];
						newc_q  <= wdata_i[`CTRL_NEWC_BIT];
						plen_q  <= req_len;
						off_q   <= 11'h000;
						sum_q   <= 8'h00;
						state_q <= H_SEND;
					end
				end
				H_SEND: begin
					if (issue) begin
						tx_data_q <= byte_w;
						off_q     <= off_q + 11'h001;
						if (off_q >= `OFS_TYPE) begin
							sum_q <= sum_q + byte_w;                     // [R14]
						end
						if (off_q == last_off) begin
							state_q <= H_SUM;
						end
					end
				end
				H_SUM: begin
					if (sum_out) begin
						tx_data_q <= `CSUM_BASE - sum_q;                 // [R14]
						state_q   <= H_IDLE;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end
endmodule : ipv4_tx_host
`default_nettype wire

/* test/ipv4_framer_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Link checker
// ********************************************************************
module ipv4_framer_checker (
	input wire logic        sys_clk_i,
	input wire logic        reset_i,
	input wire logic [7:0]  data,
	input wire logic        valid,
	input wire logic        ready,
	input wire logic [7:0]  frame_id_o,
	input wire logic [31:0] dest_addr_o,
	input wire logic        close_socket_o,
	input wire logic        broadcast_o,
	input wire logic        status_wanted_o,
	input wire logic        hdr_valid_o,
	input wire logic        frame_good_o,
	input wire logic        frame_bad_o,
	input wire logic [10:0] max_payload_query_o
);
	logic [15:0] idx_q;
	logic [15:0] len_q;
	logic [15:0] end_w;
	logic [7:0]  sum_q;
	logic [7:0]  id_q;
	logic [7:0]  proto_q;
	logic [7:0]  opt_q;
	logic [31:0] addr_q;
	wire         take_w = valid && ready;

	// Byte position is counted, not hunted, so a 0x7E inside a payload stays payload
	assign end_w = len_q + 16'h0003;

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			idx_q <= 16'h0000;
		end else if (take_w) begin
			if (idx_q == 16'h0000)
				idx_q <= {15'h0000, data == 8'h7E};
			else if (idx_q == end_w)
				idx_q <= 16'h0000;
			else
				idx_q <= idx_q + 16'h0001;
			if (idx_q == 16'h0001) len_q[15:8] <= data;
			if (idx_q == 16'h0002) len_q[7:0] <= data;
			sum_q <= (idx_q < 16'h0003) ? 8'h00 : sum_q + data;
			if (idx_q == 16'h0004) id_q <= data;
			if (idx_q >= 16'h0005 && idx_q <= 16'h0008) addr_q <= {addr_q[23:0], data};
			if (idx_q == 16'h000D) proto_q <= data;
			if (idx_q == 16'h000E) opt_q <= data;
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_byte(logic [15:0] n);
		take_w && idx_q == n;
	endsequence
	sequence s_last;
		take_w && idx_q == end_w && idx_q > 16'h0002;
	endsequence

	delim_first_a: assert property (s_byte(16'h0000) |-> data == 8'h7E)
		else $error("frame does not open with the delimiter");
	type_byte_a: assert property (s_byte(16'h0003) |-> data == 8'h20)
		else $error("frame type byte wrong");
	len_range_a: assert property (s_byte(16'h0002) |->
		{len_q[15:8], data} inside {[16'h000C:16'h0584]})
		else $error("length field out of range");
	proto_code_a: assert property (s_byte(16'h000D) |-> data <= 8'h01)
		else $error("protocol byte not 0 or 1");
	opt_reserved_a: assert property (s_byte(16'h000E) |-> (data & 8'hFD) == 8'h00)
		else $error("reserved option bits set");
	csum_value_a: assert property (s_last |-> data == 8'hFF - sum_q)
		else $error("checksum byte wrong");
	offer_hold_a: assert property (valid && !ready |=> valid && $stable(data))
		else $error("link byte changed before taken");
	hdr_pulse_a: assert property (s_byte(16'h000E) |=> hdr_valid_o)
		else $error("header valid missing");
	good_pulse_a: assert property (s_last |=> frame_good_o && !frame_bad_o)
		else $error("good frame not accepted");
	close_flag_a: assert property (frame_good_o |->
		close_socket_o == (opt_q[1] && proto_q == 8'h01))
		else $error("close flag wrong");
	bcast_flag_a: assert property (frame_good_o |-> dest_addr_o == addr_q &&
		broadcast_o == (addr_q == 32'hFFFF_FFFF && proto_q == 8'h00))
		else $error("address or broadcast wrong");
	status_flag_a: assert property (frame_good_o |-> frame_id_o == id_q &&
		status_wanted_o == (id_q != 8'h00))
		else $error("frame id or status request wrong");
	max_pay_a: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
		max_payload_query_o == 11'h570)
		else $error("reported max payload wrong");
endmodule : ipv4_framer_checker
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [39:0] HELLO_C = 40'h48_656C_6C6F;
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        we_i = 1'b0;
	logic        re_i = 1'b0;
	logic [7:0]  pay_data_i = 8'h00;
	logic        pay_valid_i = 1'b0;
	logic        pay_ready_i = 1'b1;
	logic        stall_q = 1'b0;
	logic [2:0]  cyc_q = 3'h0;
	wire  [31:0] rdata_o;
	wire         pay_ready_o;
	wire  [7:0]  frame_id_o, pay_data_o;
	wire  [31:0] dest_addr_o;
	wire  [15:0] dest_port_o, src_port_o;
	wire         proto_tcp_o, close_socket_o, broadcast_o, status_wanted_o, hdr_valid_o;
	wire         pay_valid_o, frame_good_o, frame_bad_o, frame_other_o;
	wire  [10:0] max_payload_query_o;
	int          n_fail = 0;
	int          n_tests = 0;
	logic [7:0]  lk[$];
	logic [7:0]  got[$];

	always #20 sys_clk_i = ~sys_clk_i;

	ipv4_link_if ipv4_link_if_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i));
	ipv4_tx_host ipv4_tx_host_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
		.pay_data_i(pay_data_i), .pay_valid_i(pay_valid_i), .pay_ready_o(pay_ready_o),
		.link(ipv4_link_if_i));
	ipv4_tx_device ipv4_tx_device_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.link(ipv4_link_if_i), .frame_id_o(frame_id_o), .dest_addr_o(dest_addr_o),
		.dest_port_o(dest_port_o), .src_port_o(src_port_o), .proto_tcp_o(proto_tcp_o),
		.close_socket_o(close_socket_o), .broadcast_o(broadcast_o),
		.status_wanted_o(status_wanted_o), .hdr_valid_o(hdr_valid_o),
		.pay_data_o(pay_data_o), .pay_valid_o(pay_valid_o), .pay_ready_i(pay_ready_i),
		.frame_good_o(frame_good_o), .frame_bad_o(frame_bad_o),
		.frame_other_o(frame_other_o), .max_payload_query_o(max_payload_query_o));
	ipv4_framer_checker ipv4_framer_checker_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.data(ipv4_link_if_i.data), .valid(ipv4_link_if_i.valid),
		.ready(ipv4_link_if_i.ready), .frame_id_o(frame_id_o), .dest_addr_o(dest_addr_o),
		.close_socket_o(close_socket_o), .broadcast_o(broadcast_o),
		.status_wanted_o(status_wanted_o), .hdr_valid_o(hdr_valid_o),
		.frame_good_o(frame_good_o), .frame_bad_o(frame_bad_o),
		.max_payload_query_o(max_payload_query_o));

	// ****************************************************************
	// Consumer stall and monitors
	// ****************************************************************
	// Stalling half the time forces the two-entry buffer to push back
	always @(posedge sys_clk_i) begin
		cyc_q <= cyc_q + 3'h1;
		pay_ready_i <= !stall_q || cyc_q[2];
		if (pay_valid_o && pay_ready_i) got.push_back(pay_data_o);
		if (ipv4_link_if_i.valid && ipv4_link_if_i.ready) lk.push_back(ipv4_link_if_i.data);
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic wrap_up;
		$display("%0d checks, %0d mismatches", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : wrap_up

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_i <= a;
		wdata_i <= d;
		we_i <= 1'b1;
		@(posedge sys_clk_i);
		we_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		addr_i <= a;
		re_i <= 1'b1;
		@(posedge sys_clk_i);
		re_i <= 1'b0;
		@(posedge sys_clk_i);
		check("register read", rdata_o, exp);
	endtask : rd

	function automatic logic [7:0] pb(input int k, input int n);
		if (n == 5) return HELLO_C[39-8*k -: 8];
		return k[7:0] ^ 8'hA5;
	endfunction : pb

	task automatic run_frame(input logic [7:0] id, input logic [7:0] opts, input logic tcp,
		input logic newc, input logic [31:0] dst, input int n);
		int k;
		lk.delete();
		got.delete();
		wr(8'h00, dst);
		wr(8'h04, 32'h2616_2616);
		wr(8'h08, {1'b1, 2'b00, n[10:0], newc, tcp, opts, id});
		for (k = 0; k < n; k++) begin
			pay_data_i <= pb(k, n);
			pay_valid_i <= 1'b1;
			do @(posedge sys_clk_i); while (!pay_ready_o);
		end
		pay_valid_i <= 1'b0;
		k = 0;
		while (!(frame_good_o || frame_bad_o) && k < 20000) begin
			@(posedge sys_clk_i);
			k++;
		end
		check("frame good", frame_good_o, 1'b1);
		check("frame bad", frame_bad_o, 1'b0);
		check("frame other", frame_other_o, 1'b0);
		repeat (8) @(posedge sys_clk_i);
		check("frame id", frame_id_o, id);
		check("status wanted", status_wanted_o, id != 8'h00);
		check("dest addr", dest_addr_o, dst);
		check("broadcast", broadcast_o, dst == 32'hFFFF_FFFF && !tcp);
		check("dest port", dest_port_o, 16'h2616);
		check("src port", src_port_o, (tcp && newc) ? 16'h0000 : 16'h2616);
		check("protocol", proto_tcp_o, tcp);
		check("close", close_socket_o, opts[1] && tcp);
		check("options byte", lk[14], opts & 8'h02);
		check("type byte", lk[3], 8'h20);
		check("length", {lk[1], lk[2]}, 12 + n);
		check("payload count", got.size(), n);
		for (k = 0; k < got.size(); k++) check("payload", got[k], pb(k, n));
		if (n == 5) check("checksum", lk[lk.size()-1], 8'hA6);
		rd(8'h0C, 32'h0000_0004);
		wr(8'h0C, 32'h0000_0007);
		rd(8'h0C, 32'h0000_0000);
		$display("frame test with %0d payload bytes done", n);
	endtask : run_frame

	// ****************************************************************
	// Main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (6) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		check("max payload", max_payload_query_o, 11'h570);
		run_frame(8'h01, 8'h00, 1'b0, 1'b0, 32'hC0A8_0064, 5);
		stall_q <= 1'b1;
		run_frame(8'h00, 8'hFF, 1'b1, 1'b1, 32'hFFFF_FFFF, 1400);
		run_frame(8'h7F, 8'h02, 1'b0, 1'b0, 32'hFFFF_FFFF, 1);
		run_frame(8'h02, 8'h02, 1'b1, 1'b0, 32'h0A00_0001, 3);
		lk.delete();
		wr(8'h08, {1'b1, 2'b00, 11'h579, 18'h0_0000});
		rd(8'h0C, 32'h0000_0002);
		repeat (20) @(posedge sys_clk_i);
		check("oversize sent", lk.size(), 0);
		wr(8'h0C, 32'h0000_0007);
		rd(8'h10, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		$display("register and oversize test done");
		wrap_up();
	end

	// Longest frame with a half-rate consumer needs about 2800 cycles
	initial begin
		repeat (40000) @(posedge sys_clk_i);
		n_fail++;
		$display("watchdog expired");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
